// ==== dv/oscs_ext_src.sv ====
// far-side model on the second oscillator pin
`timescale 1ns/10ps
// resonators above 3.5 MHz are only paired with high-speed mode
// an external clock on the first pin needs no model of its own
module oscs_ext_src (
    input  wire logic pclk,
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_lvl
);
    logic flip_q = 1'b0;

    // released pin has no pull: show a changing level
    always @(posedge pclk)
    begin
        flip_q <= ~flip_q;
    end

    assign pin_lvl = pin_oe ? pin_o : (drive_en ? drive_val : flip_q);
endmodule : oscs_ext_src

// ==== dv/testbench.sv ====
// self-checking bench for the oscillator mode block
`timescale 1ns/10ps
`include "oscs_defs.svh"
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
        end \
    end
module testbench;
    logic                       pclk = 1'b0;
    logic                       presetn = 1'b0;
    logic                       psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]                 paddr = 8'h00;
    logic [31:0]                pwdata = 32'h0, prdata, rd, r;
    logic                       pready, pslverr, err, osc_out_in, osc_out_o, osc_out_oe;
    logic [3:0]                 osc_config_field = 4'h0, cfg;
    logic                       sleep_req = 1'b0, pa_out = 1'b0, pa_oe = 1'b0;
    logic                       ext_en = 1'b0, ext_val = 1'b0, porta_bit6_io_in;
    logic [2:0]                 ifs;
    logic [5:0]                 v;
    logic [31:0]                lfsr_q = 32'd70366;
    oscs_pkg::oscs_clk_ctl_type clk_ctl;
    int                         n_errors = 0, total_checks = 0, n;

    always #2 pclk = ~pclk;

    oscs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_config_field(osc_config_field), .sleep_req(sleep_req),
        .osc_out_in(osc_out_in), .osc_out_o(osc_out_o), .osc_out_oe(osc_out_oe),
        .porta_bit6_io_out(pa_out), .porta_bit6_io_oe(pa_oe),
        .porta_bit6_io_in(porta_bit6_io_in), .clk_ctl(clk_ctl));
    oscs_ext_src u_ext (.pclk(pclk), .drive_en(ext_en), .drive_val(ext_val),
        .pin_o(osc_out_o), .pin_oe(osc_out_oe), .pin_lvl(osc_out_in));

    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction : rnd

    function automatic logic is_xtal(input logic [3:0] c);
        return c == `OSCS_CFG_LOW_PWR || c == `OSCS_CFG_STD_XTAL
            || c == `OSCS_CFG_FAST_XTAL || c == `OSCS_CFG_XTAL_X4;
    endfunction : is_xtal

    function automatic logic is_io(input logic [3:0] c);
        return c == `OSCS_CFG_EXT_IO || c == `OSCS_CFG_RC_IO || c == `OSCS_CFG_INT_IO;
    endfunction : is_io

    function automatic logic [3:0] f_src(input logic [2:0] f, input logic lf);
        return (f == 3'h7) ? 4'h2 : ((f == 3'h0 && !lf) ? 4'h8 : 4'h4);
    endfunction : f_src

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic restart(input logic [3:0] c);
        presetn          <= 1'b0;
        osc_config_field <= c;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        osc_config_field <= ~c;
    endtask : restart

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        for (int c = 0; c < 16; c++)
        begin
            cfg = c[3:0];
            restart(cfg);
            apb(1'b0, `OSCS_ADDR_STAT, 32'h0);
            `CHK(rd[3:0], cfg);
            apb(1'b0, `OSCS_ADDR_CTRL, 32'h0);
            `CHK(rd[6:4], 3'h6);
            `CHK(clk_ctl.mult_xtal, cfg == `OSCS_CFG_XTAL_X4);
            `CHK(clk_ctl.mult_en, cfg == `OSCS_CFG_XTAL_X4);
            `CHK(clk_ctl.clk_ready, !is_xtal(cfg));
            if (is_io(cfg))
            begin
                for (int k = 0; k < 6; k++)
                begin
                    r = rnd();
                    pa_out  <= r[0];
                    pa_oe   <= r[1];
                    ext_en  <= !r[1];
                    ext_val <= r[2];
                    @(posedge pclk);
                    `CHK(osc_out_oe, r[1]);
                    `CHK(porta_bit6_io_in, r[1] ? r[0] : r[2]);
                end
            end
            else if (!is_xtal(cfg))
            begin
                for (int k = 0; k < 6; k++)
                begin
                    v[k] = osc_out_o;
                    @(posedge pclk);
                end
                `CHK(osc_out_oe, 1'b1);
                `CHK(v[5:2], ~v[3:0]);
            end
            else
                `CHK(osc_out_oe, 1'b0);
            if (cfg == `OSCS_CFG_XTAL_X4)
            begin
                apb(1'b1, `OSCS_ADDR_TUNE, 32'h40);
                apb(1'b0, `OSCS_ADDR_TUNE, 32'h0);
                `CHK(rd[6], 1'b0);
            end
            if (cfg == `OSCS_CFG_FAST_XTAL)
            begin
                n = 0;
                while (clk_ctl.clk_ready !== 1'b1 && n < 1100)
                begin
                    @(posedge pclk);
                    n++;
                end
                `CHK(n >= 990 && n < 1100, 1'b1);
            end
            if (cfg == `OSCS_CFG_EXT_OUT)
            begin
                sleep_req <= 1'b1;
                apb(1'b0, `OSCS_ADDR_STAT, 32'h0);
                `CHK(rd[7:4], 4'h8);
                sleep_req <= 1'b0;
                repeat (2) @(posedge pclk);
                `CHK(clk_ctl.clk_ready, 1'b1);
            end
            if (cfg == `OSCS_CFG_INT_IO || cfg == `OSCS_CFG_INT_OUT)
            begin
                for (int i = 0; i < 8; i++)
                begin
                    ifs = i[2:0];
                    r   = rnd();
                    apb(1'b1, `OSCS_ADDR_CTRL, {25'h0, ifs, 4'h0});
                    apb(1'b1, `OSCS_ADDR_TUNE, {24'h0, r[7], 2'b10, r[4:0]});
                    apb(1'b0, `OSCS_ADDR_TUNE, 32'h0);
                    `CHK(rd[7:0], {r[7], ifs >= 3'h6, 1'b0, r[4:0]});
                    `CHK(clk_ctl.mult_en, ifs >= 3'h6);
                    `CHK(clk_ctl.fast_en, ifs != 3'h0 || r[7]);
                    `CHK(clk_ctl.slow_en, ifs == 3'h0 && !r[7]);
                    `CHK(clk_ctl.src, f_src(ifs, r[7]));
                    `CHK(clk_ctl.post_sel, ifs);
                end
                for (int b = 0; b < 5; b++)
                begin
                    apb(1'b1, `OSCS_ADDR_SUP, 32'h1 << b);
                    `CHK(clk_ctl.slow_en, b < 4);
                end
                apb(1'b0, 8'h10, 32'h0);
                `CHK({err, rd}, {1'b1, 32'h0});
            end
        end
        end_of_test();
    end
endmodule : testbench

// ==== verilog/oscs_defs.svh ====
// offsets, encodings and counts for the oscillator mode block
`ifndef OSCS_DEFS_SVH
`define OSCS_DEFS_SVH
`define OSCS_ADDR_CTRL     8'h00
`define OSCS_ADDR_TUNE     8'h04
`define OSCS_ADDR_SUP      8'h08
`define OSCS_ADDR_STAT     8'h0C
`define OSCS_CFG_LOW_PWR   4'h0
`define OSCS_CFG_STD_XTAL  4'h1
`define OSCS_CFG_FAST_XTAL 4'h2
`define OSCS_CFG_RC        4'h3
`define OSCS_CFG_EXT_OUT   4'h4
`define OSCS_CFG_EXT_IO    4'h5
`define OSCS_CFG_XTAL_X4   4'h6
`define OSCS_CFG_RC_IO     4'h7
`define OSCS_CFG_INT_IO    4'h8
`define OSCS_CFG_INT_OUT   4'h9
`define OSCS_IFS_8M        3'h7
`define OSCS_IFS_4M        3'h6
`define OSCS_IFS_SLOW      3'h0
`define OSCS_IFS_RST       3'h6
`define OSCS_CTRL_IFS_LSB  4
`define OSCS_TUNE_MULT_BIT 6
`define OSCS_TUNE_LFS_BIT  7
`define OSCS_START_CYCLES  11'h400
`endif

// ==== verilog/oscs_pkg.sv ====
// types of the oscillator mode block
package oscs_pkg;
    typedef enum logic [3:0] {
        ST_CAPTURE = 4'h1,
        ST_START   = 4'h2,
        ST_RUN     = 4'h4,
        ST_SLEEP   = 4'h8
    } oscs_state_type;

    typedef enum logic [3:0] {
        SRC_PRIMARY = 4'h1,
        SRC_FAST    = 4'h2,
        SRC_POST    = 4'h4,
        SRC_SLOW    = 4'h8
    } oscs_src_type;

    typedef struct packed {
        logic [3:0]     cfg;
        logic [2:0]     ifs;
        logic           lfsrc;
        logic           mult_sw;
        logic [4:0]     tune;
        logic [3:0]     sup_en;
        oscs_state_type st;
        logic [10:0]    cnt;
        logic [1:0]     div;
    } oscs_regs_type;

    typedef struct packed {
        logic         fast_en;
        logic         slow_en;
        logic         mult_en;
        logic         mult_xtal;
        oscs_src_type src;
        logic [2:0]   post_sel;
        logic         clk_ready;
    } oscs_clk_ctl_type;
endpackage : oscs_pkg

// ==== verilog/oscs_top.sv ====
// oscillator mode decode, pin control and clock source select
`timescale 1ns/10ps
`include "oscs_defs.svh"

// Summary of operation
// - external clock modes skip start-up wait
// - ext clock out mode drives clock/4
// - ext clock io mode frees pin as port bit 6
// - rc out mode drives clock/4
// - rc io mode frees pin as port bit 6
// - high-speed x4 mode multiplies crystal by four
// - software multiplier bit ignored in x4 mode
// - crystal multiplier only with code 0110
// - internal multiplier under software control only
// - fast source direct or through postscaler
// - fast source on for 125k to 8M
// - slow rc on when selected or supervised
// - frequency select picks source path
// - high-speed mode accepts external clock input
// - internal multiplier only internal modes, 110/111
// - multiplier bit reads zero when unavailable
module oscs_top (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [3:0]                osc_config_field,
    input  wire logic                      sleep_req,
    input  wire logic                      osc_out_in,
    output logic                           osc_out_o,
    output logic                           osc_out_oe,
    input  wire logic                      porta_bit6_io_out,
    input  wire logic                      porta_bit6_io_oe,
    output logic                           porta_bit6_io_in,
    output oscs_pkg::oscs_clk_ctl_type     clk_ctl
);

    oscs_pkg::oscs_regs_type r_q;
    oscs_pkg::oscs_regs_type r_d;

    logic is_ext;
    logic is_xtal;
    logic is_int;
    logic is_x4;
    logic io6;
    logic div4out;
    logic mult_avail;
    logic in_xtal;
    logic wr_acc;
    logic rd_acc;
    logic mapped;

    // mode decode from captured field, in_xtal from the live field; an external clock driven into the
    // first pin in high-speed mode uses the same primary path
    always_comb
    begin
        is_ext     = (r_q.cfg == `OSCS_CFG_EXT_OUT) || (r_q.cfg == `OSCS_CFG_EXT_IO);
        is_x4      = (r_q.cfg == `OSCS_CFG_XTAL_X4);
        is_xtal    = (r_q.cfg == `OSCS_CFG_LOW_PWR) || (r_q.cfg == `OSCS_CFG_STD_XTAL)
                     || (r_q.cfg == `OSCS_CFG_FAST_XTAL) || is_x4;
        is_int     = (r_q.cfg == `OSCS_CFG_INT_OUT) || (r_q.cfg == `OSCS_CFG_INT_IO);
        io6        = (r_q.cfg == `OSCS_CFG_EXT_IO) || (r_q.cfg == `OSCS_CFG_RC_IO)
                     || (r_q.cfg == `OSCS_CFG_INT_IO);
        div4out    = !io6 && !is_xtal;
        mult_avail = is_int && ((r_q.ifs == `OSCS_IFS_8M) || (r_q.ifs == `OSCS_IFS_4M));
        in_xtal    = (osc_config_field == `OSCS_CFG_LOW_PWR)
                     || (osc_config_field == `OSCS_CFG_STD_XTAL)
                     || (osc_config_field == `OSCS_CFG_FAST_XTAL)
                     || (osc_config_field == `OSCS_CFG_XTAL_X4);
    end

    // apb access decode
    always_comb
    begin
        wr_acc = psel && penable && pwrite;
        rd_acc = psel && !pwrite;
        if (paddr == `OSCS_ADDR_CTRL)
            mapped = 1'b1;
        else if (paddr == `OSCS_ADDR_TUNE)
            mapped = 1'b1;
        else if (paddr == `OSCS_ADDR_SUP)
            mapped = 1'b1;
        else if (paddr == `OSCS_ADDR_STAT)
            mapped = 1'b1;
        else
            mapped = 1'b0;
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // read mux
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_acc && paddr == `OSCS_ADDR_CTRL)
            prdata[6:4] = r_q.ifs;
        else if (rd_acc && paddr == `OSCS_ADDR_TUNE)
        begin
            prdata[7] = r_q.lfsrc;
            prdata[6] = r_q.mult_sw && mult_avail;
            prdata[4:0] = r_q.tune;
        end
        else if (rd_acc && paddr == `OSCS_ADDR_SUP)
            prdata[3:0] = r_q.sup_en;
        else if (rd_acc && paddr == `OSCS_ADDR_STAT)
        begin
            prdata[3:0] = r_q.cfg;
            prdata[7:4] = r_q.st;
            prdata[8]   = clk_ctl.mult_en;
            prdata[9]   = clk_ctl.fast_en;
            prdata[10]  = clk_ctl.slow_en;
        end
    end

    // next state
    always_comb
    begin
        r_d     = r_q;
        r_d.div = r_q.div + 2'h1;
        if (wr_acc && paddr == `OSCS_ADDR_CTRL)
            r_d.ifs = pwdata[`OSCS_CTRL_IFS_LSB +: 3];
        else if (wr_acc && paddr == `OSCS_ADDR_TUNE)
        begin
            r_d.lfsrc = pwdata[`OSCS_TUNE_LFS_BIT];
            r_d.tune  = pwdata[4:0];
            if (mult_avail)
                r_d.mult_sw = pwdata[`OSCS_TUNE_MULT_BIT];
        end
        else if (wr_acc && paddr == `OSCS_ADDR_SUP)
            r_d.sup_en = pwdata[3:0];
        case (r_q.st)
            oscs_pkg::ST_CAPTURE:
            begin
                r_d.cfg = osc_config_field;
                if (in_xtal)
                begin
                    r_d.st  = oscs_pkg::ST_START;
                    r_d.cnt = `OSCS_START_CYCLES;
                end
                else
                    r_d.st = oscs_pkg::ST_RUN;
            end
            oscs_pkg::ST_START:
            begin
                r_d.cnt = r_q.cnt - 11'h001;
                if (r_q.cnt == 11'h001)
                    r_d.st = oscs_pkg::ST_RUN;
            end
            oscs_pkg::ST_RUN:
            begin
                if (sleep_req)
                    r_d.st = oscs_pkg::ST_SLEEP;
            end
            oscs_pkg::ST_SLEEP:
            begin
                if (!sleep_req && is_xtal)
                begin
                    r_d.st  = oscs_pkg::ST_START;
                    r_d.cnt = `OSCS_START_CYCLES;
                end
                else if (!sleep_req)
                    r_d.st = oscs_pkg::ST_RUN;
            end
            default:
                r_d.st = oscs_pkg::ST_CAPTURE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q.cfg     <= `OSCS_CFG_LOW_PWR;
            r_q.ifs     <= `OSCS_IFS_RST;
            r_q.lfsrc   <= 1'b0;
            r_q.mult_sw <= 1'b0;
            r_q.tune    <= 5'h00;
            r_q.sup_en  <= 4'h0;
            r_q.st      <= oscs_pkg::ST_CAPTURE;
            r_q.cnt     <= 11'h000;
            r_q.div     <= 2'h0;
        end
        else
            r_q <= r_d;
    end

    // second oscillator pin: clock/4, port bit 6, or released
    always_comb
    begin
        porta_bit6_io_in = 1'b0;
        if (io6)
        begin
            osc_out_o        = porta_bit6_io_out;
            osc_out_oe       = porta_bit6_io_oe;
            porta_bit6_io_in = osc_out_in;
        end
        else if (div4out)
        begin
            osc_out_o  = r_q.div[1];
            osc_out_oe = 1'b1;
        end
        else
        begin
            osc_out_o  = 1'b0;
            osc_out_oe = 1'b0;
        end
    end

    // clock source control
    always_comb
    begin
        clk_ctl.mult_xtal = is_x4;
        clk_ctl.mult_en   = is_x4 || (mult_avail && r_q.mult_sw);
        clk_ctl.post_sel  = r_q.ifs;
        clk_ctl.clk_ready = (r_q.st == oscs_pkg::ST_RUN);
        if (!is_int)
            clk_ctl.src = oscs_pkg::SRC_PRIMARY;
        else if (r_q.ifs == `OSCS_IFS_8M)
            clk_ctl.src = oscs_pkg::SRC_FAST;
        else if (r_q.ifs == `OSCS_IFS_SLOW && !r_q.lfsrc)
            clk_ctl.src = oscs_pkg::SRC_SLOW;
        else
            clk_ctl.src = oscs_pkg::SRC_POST;
        clk_ctl.fast_en = is_int && ((r_q.ifs != `OSCS_IFS_SLOW) || r_q.lfsrc);
        clk_ctl.slow_en = (clk_ctl.src == oscs_pkg::SRC_SLOW) || (r_q.sup_en != 4'h0);
    end

    a_ext_no_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_q.st == oscs_pkg::ST_CAPTURE && (osc_config_field == `OSCS_CFG_EXT_OUT
         || osc_config_field == `OSCS_CFG_EXT_IO)) |=> clk_ctl.clk_ready)
        else $error("external clock mode waited for start-up");

    a_ext_sleep_exit: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_q.st == oscs_pkg::ST_SLEEP && !sleep_req && is_ext) |=> clk_ctl.clk_ready)
        else $error("external clock mode waited after sleep");

    a_div4_wave: assert property (
        @(posedge pclk) disable iff (!presetn)
        (div4out && $rose(osc_out_o)) |-> ##1 osc_out_o ##1 !osc_out_o ##1 !osc_out_o)
        else $error("second pin is not clock divided by four");

    a_rc_pin_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_q.cfg == `OSCS_CFG_RC) |-> osc_out_oe && osc_out_o == r_q.div[1])
        else $error("rc mode does not drive clock/4");

    a_io_pass: assert property (
        @(posedge pclk) disable iff (!presetn)
        io6 |-> osc_out_oe == porta_bit6_io_oe && osc_out_o == porta_bit6_io_out)
        else $error("port bit 6 not routed to pin");

    a_rc_io_mode_input: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_q.cfg == `OSCS_CFG_RC_IO) |-> porta_bit6_io_in == osc_out_in)
        else $error("pin input not returned to port bit 6");

    a_x4_crystal: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_ctl.mult_xtal |-> r_q.cfg == `OSCS_CFG_XTAL_X4 && clk_ctl.mult_en)
        else $error("crystal multiplier outside x4 mode");

    a_sw_ignored: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `OSCS_ADDR_TUNE && !mult_avail) |=> $stable(r_q.mult_sw))
        else $error("multiplier bit written while unavailable");

    a_int_mult: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clk_ctl.mult_en && !is_x4) |-> is_int && r_q.ifs[2:1] == 2'h3 && r_q.mult_sw)
        else $error("internal multiplier enabled illegally");

    a_read_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == `OSCS_ADDR_TUNE && !mult_avail) |-> !prdata[6])
        else $error("multiplier bit reads one while unavailable");

    a_slow_auto: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_q.sup_en != 4'h0) |-> clk_ctl.slow_en)
        else $error("slow rc off with supervisor enabled");

    a_cfg_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_q.st != oscs_pkg::ST_CAPTURE) |=> $stable(r_q.cfg))
        else $error("configuration changed after capture");

    a_fast_on: assert property (
        @(posedge pclk) disable iff (!presetn)
        (is_int && r_q.ifs != `OSCS_IFS_SLOW) |-> clk_ctl.fast_en)
        else $error("fast source off while selected");

    a_fast_direct: assert property (
        @(posedge pclk) disable iff (!presetn)
        (is_int && r_q.ifs == `OSCS_IFS_8M) |-> clk_ctl.src == oscs_pkg::SRC_FAST)
        else $error("full-rate select not on direct path");

endmodule : oscs_top
